// ===== hw/cem_regs.sv
/*
  cem_regs: apb slave holding the clock source / channel enable register,
  the interrupt mask register, the interrupt status register and the
  multiplier-enable bits, decoding the clock selections into ratios.
  assumes: one clock, apb master per amba apb3, events are one-cycle pulses.
  assumes: host software sets the multiplier-enable bits before it asks for
  x4, x8 or x16; this block decodes the selection but does not gate it.
*/
// Implementation choice: the APB interface to the registers.
// Function
// - master clock code 000 pin, 001..101 x1..x16, 110/111 no clock
// - input divider code 00 /1, 01 /2, 10 /3, 11 no clock
// - input divider acts only when master clock comes from multiplier
// - dsp ratio 000 x8, 001 x4, 010 x2, 011 x1, 100 x16, else none
// - dac, current adc and voltage adc enable bits: 1 on, 0 off
// - watchdog interrupt blocked while its mask bit is 1
// - outbound data interrupt blocked while its mask bit is 1
// - emergency shutdown interrupt blocked while its mask bit is 1
// - clip and low supply interrupts each blocked by own mask bit
// - over-voltage interrupt blocked while its mask bit is 1
// - power-up interrupt blocked while its mask bit is 1
// - writing one to status bits 6:0 clears them
// - status bits: 6 wdog, 5 outbound, 4 shutdown, 3 clip, 2 low, 1 ovp, 0 pwrup
`timescale 1ns/1ps
module cem_regs
  import cem_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [CEM_ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]            pwdata_i,
  input  wire logic [3:0]             pstrb_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic [CEM_NUM_IRQ-1:0] event_i,
  output logic                        irq_o,
  output cem_clkcfg_s                 clkcfg_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the decode takes an 8-bit index out of a 10-bit byte address
  if (CEM_ADDR_W != 10) begin : g_chk_addr
    $error("byte address must be 10 bits wide");
  end
  // status, mask and read mux are laid out for seven sources
  if (CEM_NUM_IRQ != 7) begin : g_chk_irq
    $error("interrupt source count must be 7");
  end
  // clock fields must stay inside the 16-bit register and apart
  if ((CEM_F_MCLK_LSB + 3 > 16) || (CEM_F_DIV_LSB + 2 > CEM_F_MCLK_LSB) ||
      (CEM_F_DSP_LSB + 3 > CEM_F_DIV_LSB)) begin : g_chk_fld
    $error("clock fields overlap or leave the register");
  end
  // channel bits sit below the dsp ratio field
  if ((CEM_F_DAC >= CEM_F_DSP_LSB) || (CEM_F_ADCI >= CEM_F_DAC) || (CEM_F_ADCV >= CEM_F_ADCI)) begin : g_chk_chan
    $error("channel enable bits overlap the clock fields");
  end

  // ****************************************
  // apb decode
  // ****************************************
  // register state and next values
  logic [15:0]            enable_r;
  logic [CEM_NUM_IRQ-1:0] mask_r;
  logic [CEM_NUM_IRQ-1:0] status_r;
  logic [3:0]             mulen_r;
  logic [CEM_NUM_IRQ-1:0] status_nxt;
  logic [31:0]            rdata_nxt;
  logic [15:0]            wr16;

  // access phase strobes
  wire       access  = psel_i & penable_i;
  wire       wr_en   = access & pwrite_i;
  wire       aligned = (paddr_i[1:0] == 2'b00);
  // register selects; unaligned bytes never hit
  wire [7:0] idx     = paddr_i[CEM_ADDR_W-1:2];
  wire       hit_en  = aligned & (idx == CEM_IDX_ENABLE);
  wire       hit_msk = aligned & (idx == CEM_IDX_MASK);
  wire       hit_st  = aligned & (idx == CEM_IDX_STATUS);
  wire       hit_mul = aligned & (idx == CEM_IDX_MULEN);
  wire       mapped  = hit_en | hit_msk | hit_st | hit_mul;

  // zero-wait slave; unmapped address answers with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;

  // byte lanes merged into the current 16-bit value
  always_comb begin
    wr16 = enable_r;
    if (hit_msk) begin
      wr16 = {9'h00, mask_r};
    end else if (hit_mul) begin
      wr16 = {12'h000, mulen_r};
    end
    if (pstrb_i[0]) begin
      wr16[7:0] = pwdata_i[7:0];
    end
    if (pstrb_i[1]) begin
      wr16[15:8] = pwdata_i[15:8];
    end
  end

  // read mux, upper bits read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_en) begin
      rdata_nxt = {16'h0000, enable_r};
    end else if (hit_msk) begin
      rdata_nxt = {25'h00_0000, mask_r};
    end else if (hit_st) begin
      rdata_nxt = {25'h00_0000, status_r};
    end else if (hit_mul) begin
      rdata_nxt = {28'h000_0000, mulen_r};
    end
  end
  // combinational read keeps zero wait states; data stands whenever the address hits, access or not
  assign prdata_o = rdata_nxt;

  // ****************************************
  // registers
  // ****************************************
  // write takes effect only on the access edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_r <= CEM_ENABLE_RST;
      mask_r   <= CEM_MASK_RST;
      mulen_r  <= 4'h0;
    end else if (wr_en) begin
      if (hit_en) begin
        enable_r <= wr16;
      end
      if (hit_msk) begin
        mask_r <= wr16[CEM_NUM_IRQ-1:0];
      end
      if (hit_mul) begin
        mulen_r <= wr16[3:0];
      end
    end
  end

  // ****************************************
  // interrupt status and output
  // ****************************************
  // status: a new event wins over a write-one clear in the same cycle,
  // so a source firing while software clears it is never lost
  wire clr_en = wr_en & hit_st & pstrb_i[0];
  generate
    for (genvar g = 0; g < CEM_NUM_IRQ; g++) begin : g_stat
      // masking does not stop recording
      assign status_nxt[g] = event_i[g] | (status_r[g] & ~(clr_en & pwdata_i[g]));
    end
  endgenerate

  // status clears only on reset or by write-one; no read side effect
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // blocked sources never reach the output
  // level taken from flops only, so event pulses cannot glitch it
  assign irq_o = |(status_r & ~mask_r);

  // ****************************************
  // clock selection decode
  // ****************************************
  // raw field codes straight from the enable register
  wire [2:0] mclk_code = enable_r[CEM_F_MCLK_LSB +: 3];
  wire [1:0] div_code  = enable_r[CEM_F_DIV_LSB +: 2];
  wire [2:0] dsp_code  = enable_r[CEM_F_DSP_LSB +: 3];
  // decoded ratios, 0 means no clock
  logic [4:0] mult_w;
  logic [4:0] dsp_w;
  logic [1:0] div_w;

  // master clock source
  always_comb begin
    case (cem_mclk_e'(mclk_code))
      CEM_MCLK_X1:  mult_w = 5'h01;
      CEM_MCLK_X2:  mult_w = 5'h02;
      CEM_MCLK_X4:  mult_w = 5'h04;
      CEM_MCLK_X8:  mult_w = 5'h08;
      CEM_MCLK_X16: mult_w = 5'h10;
      default:      mult_w = 5'h00;
    endcase
  end

  // divider only matters in front of the multiplier
  always_comb begin
    div_w = 2'h0;
    if (mult_w != 5'h00) begin
      case (div_code)
        2'b00:   div_w = 2'h1;
        2'b01:   div_w = 2'h2;
        2'b10:   div_w = 2'h3;
        default: div_w = 2'h0;
      endcase
    end
  end

  // dsp core ratio
  always_comb begin
    case (dsp_code)
      3'b000:  dsp_w = 5'h08;
      3'b001:  dsp_w = 5'h04;
      3'b010:  dsp_w = 5'h02;
      3'b011:  dsp_w = 5'h01;
      3'b100:  dsp_w = 5'h10;
      default: dsp_w = 5'h00;
    endcase
  end

  // ****************************************
  // clock selection outputs
  // ****************************************
  // x4/x8/x16 trust software to have set mulen first (no hardware gate);
  // a gate here would hide a software slip instead of showing it
  wire mclk_pin_w = (mclk_code == CEM_MCLK_PIN);
  assign clkcfg_o = '{
    mclk_from_pin:          mclk_pin_w,
    mclk_mult:              mult_w,
    mul_in_div:             div_w,
    dsp_ratio:              dsp_w,
    dac_channel_on:         enable_r[CEM_F_DAC],
    current_adc_channel_on: enable_r[CEM_F_ADCI],
    voltage_adc_channel_on: enable_r[CEM_F_ADCV]
  };

  // ****************************************
  // assertions
  // ****************************************
  // output, status, enable write and clock decode
  AST_IRQ_MASKED: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (status_r & ~mask_r) == '0 |-> !irq_o)
    else $error("irq high with nothing unmasked");
  AST_IRQ_RAISE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    event_i[0] && !mask_r[0] && !(wr_en && hit_msk) |=> irq_o)
    else $error("unmasked power-up event gave no irq");
  AST_WDOG: assert property (@(posedge clock_i) disable iff (!nrst_i)
    event_i[6] |=> status_r[6])
    else $error("watchdog event not recorded");
  AST_CLR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    clr_en && pwdata_i[3] && !event_i[3] |=> !status_r[3])
    else $error("clip clear failed");
  AST_HOLD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    status_r[2] && !clr_en |=> status_r[2])
    else $error("low supply status lost");
  AST_ENWR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_en && hit_en && pstrb_i == 4'hF |=> enable_r == $past(pwdata_i[15:0]))
    else $error("enable write lost");
  AST_DIV: assert property (@(posedge clock_i) disable iff (!nrst_i)
    mclk_code == 3'b000 |-> div_w == 2'h0)
    else $error("divider active on pin clock");
  AST_DSP: assert property (@(posedge clock_i) disable iff (!nrst_i)
    dsp_code == 3'b100 |-> dsp_w == 5'h10)
    else $error("dsp x16 decode wrong");
  AST_MCLK: assert property (@(posedge clock_i) disable iff (!nrst_i)
    mclk_code[2:1] == 2'b11 |-> mult_w == 5'h00)
    else $error("no-clock code gave a clock");
  AST_OVP: assert property (@(posedge clock_i) disable iff (!nrst_i)
    mask_r[1] && status_r[1] && (status_r & ~mask_r) == '0 |-> !irq_o)
    else $error("ovp leaked");
  // further register writes, refused writes and decode corners
  AST_MASK_WR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_en && hit_msk && pstrb_i[0] |=> mask_r == $past(pwdata_i[CEM_NUM_IRQ-1:0]))
    else $error("mask write lost");
  AST_MULEN_WR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_en && hit_mul && pstrb_i[0] |=> mulen_r == $past(pwdata_i[3:0]))
    else $error("multiplier enable write lost");
  AST_BAD_WR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_en && !mapped |=> $stable(enable_r) && $stable(mask_r) && $stable(mulen_r))
    else $error("refused write changed a register");
  AST_CH_WR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_en && hit_en && pstrb_i[0] |=> clkcfg_o.dac_channel_on == $past(pwdata_i[CEM_F_DAC]))
    else $error("dac channel enable did not follow write");
  AST_PIN_FLAG: assert property (@(posedge clock_i) disable iff (!nrst_i)
    clkcfg_o.mclk_from_pin |-> clkcfg_o.mclk_mult == 5'h00 && clkcfg_o.mul_in_div == 2'h0)
    else $error("pin clock reported a multiplier path");
  AST_DIV_PASS: assert property (@(posedge clock_i) disable iff (!nrst_i)
    mult_w != 5'h00 && div_code == 2'b10 |-> div_w == 2'h3)
    else $error("divide by three decode wrong");
  AST_NOCLK_DSP: assert property (@(posedge clock_i) disable iff (!nrst_i)
    dsp_code[2] && dsp_code[1:0] != 2'b00 |-> dsp_w == 5'h00)
    else $error("dsp no-clock code gave a clock");

  // per source: own mask bit decides, set beats clear, nothing appears unasked
  generate
    for (genvar s = 0; s < CEM_NUM_IRQ; s++) begin : g_src_chk
      AST_SRC_PASS: assert property (@(posedge clock_i) disable iff (!nrst_i)
        event_i[s] && !mask_r[s] && !(wr_en && hit_msk) |=> irq_o)
        else $error("unblocked source gave no irq");
      AST_SRC_BLOCK: assert property (@(posedge clock_i) disable iff (!nrst_i)
        $onehot(event_i) && event_i[s] && mask_r[s] && (status_r & ~mask_r) == '0 &&
        !(wr_en && hit_msk) |=> !irq_o)
        else $error("blocked source reached irq");
      AST_SET_WINS: assert property (@(posedge clock_i) disable iff (!nrst_i)
        clr_en && pwdata_i[s] && event_i[s] |=> status_r[s])
        else $error("event lost to a clear in the same cycle");
      AST_NO_SPUR: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !status_r[s] && !event_i[s] |=> !status_r[s])
        else $error("status bit set with no event");
    end
  endgenerate

  // ****************************************
  // cover points
  // ****************************************
  COV_IRQ:   cover property (@(posedge clock_i) disable iff (!nrst_i) event_i[5] && !mask_r[5] ##1 irq_o);
  COV_RACE:  cover property (@(posedge clock_i) disable iff (!nrst_i) clr_en && pwdata_i[4] && event_i[4]);
  COV_X16:   cover property (@(posedge clock_i) disable iff (!nrst_i) mult_w == 5'h10);
  COV_ERR:   cover property (@(posedge clock_i) disable iff (!nrst_i) pslverr_o);
  COV_MASKED: cover property (@(posedge clock_i) disable iff (!nrst_i)
    event_i[6] && mask_r[6] ##1 status_r[6] && !irq_o);

endmodule : cem_regs

// ===== common/cem_pkg.sv
/*
  cem_pkg: register map, field layout, reset values and codes of the clock
  source / channel enable and interrupt mask register bank.
  assumes: 32-bit apb data, one aligned word per register.
*/
package cem_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0]  CEM_IDX_ENABLE  = 8'h04;
  localparam logic [7:0]  CEM_IDX_MASK    = 8'h05;
  localparam logic [7:0]  CEM_IDX_STATUS  = 8'h06;
  localparam logic [7:0]  CEM_IDX_MULEN   = 8'h68;
  localparam int          CEM_ADDR_W      = 10;
  localparam logic [15:0] CEM_ENABLE_RST  = 16'h0000;
  localparam logic [6:0]  CEM_MASK_RST    = 7'h7F;
  localparam int          CEM_NUM_IRQ     = 7;

  // ****************************************
  // enable register field positions
  // ****************************************
  localparam int CEM_F_MCLK_LSB = 8;   // master clock source, 3 bits
  localparam int CEM_F_DIV_LSB  = 6;   // multiplier input divider, 2 bits
  localparam int CEM_F_DSP_LSB  = 3;   // dsp core ratio, 3 bits
  localparam int CEM_F_DAC      = 2;
  localparam int CEM_F_ADCI     = 1;
  localparam int CEM_F_ADCV     = 0;

  // ****************************************
  // field codes
  // ****************************************
  typedef enum logic [2:0] {
    CEM_MCLK_PIN = 3'b000, CEM_MCLK_X1 = 3'b001, CEM_MCLK_X2 = 3'b010,
    CEM_MCLK_X4  = 3'b011, CEM_MCLK_X8 = 3'b100, CEM_MCLK_X16 = 3'b101,
    CEM_MCLK_NONE_A = 3'b110, CEM_MCLK_NONE_B = 3'b111
  } cem_mclk_e;

  typedef struct packed {
    logic       mclk_from_pin;  // master clock taken from the pin
    logic [4:0] mclk_mult;      // multiplier ratio, 0 = no clock
    logic [1:0] mul_in_div;     // divider ratio 1..3, 0 = no clock
    logic [4:0] dsp_ratio;      // dsp core ratio, 0 = no clock
    logic       dac_channel_on;
    logic       current_adc_channel_on;
    logic       voltage_adc_channel_on;
  } cem_clkcfg_s;

endpackage : cem_pkg

// ===== test/cem_host_model.sv
/*
  cem_host_model: apb master standing in for host software.
  assumes: caller enters just after a rising edge; any number of wait states.
*/
`timescale 1ns/1ps
module cem_host_model
  import cem_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic [31:0]           prdata_i,
  input  wire logic                  pready_i,
  input  wire logic                  pslverr_i,
  output logic                       psel_o,
  output logic                       penable_o,
  output logic                       pwrite_o,
  output logic      [CEM_ADDR_W-1:0] paddr_o,
  output logic      [31:0]           pwdata_o
);
  // ****************************************
  // idle bus, then one transfer per call
  // ****************************************
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = '0;
    pwdata_o  = '0;
  end
  // released lines show inverted data so stale values never pass
  task automatic xfer(input logic wr, input logic [CEM_ADDR_W-1:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= addr;
    pwdata_o <= wdata;
    @(posedge clock_i);
    penable_o <= 1'b1;
    do @(posedge clock_i); while (pready_i !== 1'b1);
    rdata = prdata_i;
    err   = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~addr;
    pwdata_o  <= ~wdata;
    @(posedge clock_i); // idle cycle keeps one assignment per time step
  endtask : xfer
endmodule : cem_host_model

// ===== test/clock_enable_irq_mask_regs_tb.sv
/*
  clock_enable_irq_mask_regs_tb: self-checking bench of cem_regs.
  assumes: cem_host_model drives apb; events are one-cycle pulses.
*/
`timescale 1ns/1ps
module clock_enable_irq_mask_regs_tb;
  import cem_pkg::*;
  logic clock_i, nrst_i, psel, penable, pwrite, pready, pslverr, irq;
  logic [CEM_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata;
  logic [6:0]            ev;
  cem_clkcfg_s           cfg;
  int                    num_errors = 0, n_tests = 0, cycles = 0;
  localparam logic [9:0] A_EN = {CEM_IDX_ENABLE, 2'b00}, A_MK = {CEM_IDX_MASK, 2'b00};
  localparam logic [9:0] A_ST = {CEM_IDX_STATUS, 2'b00}, A_MU = {CEM_IDX_MULEN, 2'b00};
  // ****************************************
  // clock, instances, timeout
  // ****************************************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  cem_regs dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .event_i(ev), .irq_o(irq), .clkcfg_o(cfg));
  cem_host_model host_u (.clock_i(clock_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  // a hang counts as a mismatch
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host_u.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd
  task automatic pulse(input int b);
    ev <= 7'(1 << b);
    @(posedge clock_i);
    ev <= 7'h00;
    @(posedge clock_i);
  endtask : pulse
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    nrst_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd(A_EN, 32'h0);
    rd(A_MK, 32'h7F);
    rd(A_ST, 32'h0);
    rd(A_MU, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'({cfg.mclk_from_pin, cfg.mul_in_div, cfg.dsp_ratio}), 32'h88);
    $display("test_reset done");
  endtask : test_reset
  // every code of every clock field, channel bits counting along
  task automatic test_clk();
    int          mult[8] = '{0, 1, 2, 4, 8, 16, 0, 0};
    int          dsp[8]  = '{8, 4, 2, 1, 16, 0, 0, 0};
    int          dv[4]   = '{1, 2, 3, 0};
    logic [15:0] d;
    wr(A_MU, 32'hF);
    rd(A_MU, 32'hF);
    for (int i = 0; i < 8; i++) begin
      d = {5'(i), 3'(i), 2'(i % 4), 3'(i), 3'(i)};
      wr(A_EN, {16'h0, d});
      rd(A_EN, {16'h0, d});
      chk(32'(cfg.mclk_from_pin), 32'(i == 0));
      chk(32'(cfg.mclk_mult), 32'(mult[i]));
      chk(32'(cfg.mul_in_div), (i >= 1 && i <= 5) ? 32'(dv[i % 4]) : 32'h0);
      chk(32'(cfg.dsp_ratio), 32'(dsp[i]));
      chk(32'({cfg.dac_channel_on, cfg.current_adc_channel_on, cfg.voltage_adc_channel_on}), 32'(i % 8));
    end
    $display("test_clk done");
  endtask : test_clk
  // each source: recorded while masked, raised when unmasked, cleared by one
  task automatic test_irq();
    for (int b = 0; b < 7; b++) begin
      pulse(b);
      chk(32'(irq), 32'h0);
      rd(A_ST, 32'(1 << b));
      wr(A_MK, 32'(~(1 << b) & 8'h7F));
      chk(32'(irq), 32'h1);
      wr(A_ST, 32'(1 << b));
      chk(32'(irq), 32'h0);
      pulse((b + 1) % 7);
      chk(32'(irq), 32'h0);
      wr(A_ST, 32'h7F);
      rd(A_ST, 32'h0);
      wr(A_MK, 32'h7F);
    end
    $display("test_irq done");
  endtask : test_irq
  // event and write-one clear in the same access cycle: the event stays
  task automatic test_race();
    fork
      wr(A_ST, 32'h10);
      begin
        @(posedge clock_i);
        ev <= 7'h10;
        @(posedge clock_i);
        ev <= 7'h00;
      end
    join
    rd(A_ST, 32'h10);
    wr(A_ST, 32'h10);
    rd(A_ST, 32'h0);
    $display("test_race done");
  endtask : test_race
  // unmapped and unaligned places are refused and leave state alone
  task automatic test_bad();
    logic [31:0] r;
    logic        e;
    host_u.xfer(1'b0, 10'h3FC, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    host_u.xfer(1'b1, 10'h011, 32'hFFFF, r, e);
    chk(32'(e), 32'h1);
    rd(A_EN, 32'h0);
    $display("test_bad done");
  endtask : test_bad
  // ****************************************
  // main sequence and verdict
  // ****************************************
  task automatic give_verdict();
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    nrst_i = 1'b0;
    ev     = 7'h00;
    test_reset();
    test_clk();
    test_reset();
    test_irq();
    test_race();
    test_bad();
    give_verdict();
  end
endmodule : clock_enable_irq_mask_regs_tb
